// ==== include/cfca_pkg.sv ====
/*
 * cfca_pkg: register offsets, reset values, field widths and state codes of the
 * coarse frequency confidence averager.
 * assumes: a byte-wide register port with 16-bit addresses, one 100 MHz clock.
 */
package cfca_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] CFCA_OFS_ABS_FLOOR = 16'h0720;
	localparam logic [15:0] CFCA_OFS_REL_FLOOR_OFS = 16'h0721;
	localparam logic [15:0] CFCA_OFS_LOWER_STEP = 16'h0722;
	localparam logic [15:0] CFCA_OFS_BAD_RUN_LO = 16'h0723;
	localparam logic [15:0] CFCA_OFS_BAD_RUN_HI = 16'h0724;
	localparam logic [15:0] CFCA_OFS_ABS_CEIL = 16'h0726;
	localparam logic [15:0] CFCA_OFS_REL_CEIL_OFS = 16'h0727;
	localparam logic [15:0] CFCA_OFS_RAISE_STEP = 16'h0728;
	localparam logic [15:0] CFCA_OFS_GOOD_RUN_LO = 16'h0729;
	localparam logic [15:0] CFCA_OFS_GOOD_RUN_HI = 16'h072A;
	localparam logic [15:0] CFCA_OFS_INIT_DELAY = 16'h072B;
	localparam logic [15:0] CFCA_OFS_CUR_THR = 16'h072D;
	localparam logic [15:0] CFCA_OFS_RAW_EST_LO = 16'h0730;
	localparam logic [15:0] CFCA_OFS_RAW_EST_HI = 16'h0731;
	localparam logic [15:0] CFCA_OFS_RAW_CONF = 16'h0735;
	localparam logic [15:0] CFCA_OFS_AVG_EST_LO = 16'h0740;
	localparam logic [15:0] CFCA_OFS_AVG_EST_HI = 16'h0741;
	localparam logic [15:0] CFCA_OFS_AVG_CONF = 16'h0745;
	localparam logic [15:0] CFCA_OFS_LOOP_EST_LO = 16'h0750;
	localparam logic [15:0] CFCA_OFS_LOOP_EST_HI = 16'h0751;
	localparam logic [15:0] CFCA_OFS_LOOP_CONF = 16'h0755;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CFCA_RST_ABS_FLOOR = 8'h90;
	localparam logic [7:0] CFCA_RST_REL_FLOOR_OFS = 8'h08;
	localparam logic [7:0] CFCA_RST_LOWER_STEP = 8'h01;
	localparam logic [9:0] CFCA_RST_BAD_RUN = 10'h020;
	localparam logic [7:0] CFCA_RST_ABS_CEIL = 8'hFF;
	localparam logic [7:0] CFCA_RST_REL_CEIL_OFS = 8'h06;
	localparam logic [7:0] CFCA_RST_RAISE_STEP = 8'h01;
	localparam logic [9:0] CFCA_RST_GOOD_RUN = 10'h001;
	localparam logic [4:0] CFCA_RST_INIT_DELAY = 5'h17;
	localparam logic [7:0] CFCA_RST_THR = 8'h90;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int CFCA_EST_W = 16;
	localparam int CFCA_CONF_W = 8;
	localparam int CFCA_RUN_W = 10;
	localparam int CFCA_DLY_W = 5;
	localparam int CFCA_WIN_DEPTH = 32;
	localparam int CFCA_IDX_W = 5;
	localparam int CFCA_CNT_W = 6;
	localparam int CFCA_SUM_W = 21;

	// ----------------------------------------------------------------
	// processing states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		CFCA_ST_IDLE = 5'b00001,
		CFCA_ST_PUSH = 5'b00010,
		CFCA_ST_ADAPT = 5'b00100,
		CFCA_ST_DIV = 5'b01000,
		CFCA_ST_DONE = 5'b10000
	} cfca_state_e;

endpackage

// ==== hw/cfca_window.sv ====
/*
 * cfca_window: sliding window of the latest estimates with their confidence and
 * good flag; gives the largest confidence, the sum and count of good estimates.
 * assumes: push is a one-cycle strobe, len is 1..depth.
 */
`timescale 1ns/1ps
module cfca_window
	import cfca_pkg::*;
#(
	parameter int DEPTH = CFCA_WIN_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic push_i,
	input wire logic [CFCA_EST_W-1:0] freq_i,
	input wire logic [CFCA_CONF_W-1:0] conf_i,
	input wire logic good_i,
	input wire logic [CFCA_CNT_W-1:0] len_i,
	output logic [CFCA_CONF_W-1:0] max_conf_o,
	output logic signed [CFCA_SUM_W-1:0] good_sum_o,
	output logic [CFCA_CNT_W-1:0] good_cnt_o
);

	logic [CFCA_EST_W-1:0] freq_q [DEPTH];
	logic [CFCA_CONF_W-1:0] conf_q [DEPTH];
	logic [DEPTH-1:0] good_q;
	logic [DEPTH-1:0] full_q;
	logic [CFCA_IDX_W-1:0] wptr_q;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wptr_q <= '0;
			good_q <= '0;
			full_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				freq_q[i] <= '0;
				conf_q[i] <= '0;
			end
		end else if (push_i) begin
			wptr_q <= wptr_q + 1'b1;
			good_q[wptr_q] <= good_i;
			full_q[wptr_q] <= 1'b1;
			freq_q[wptr_q] <= freq_i;
			conf_q[wptr_q] <= conf_i;
		end
	end

	// ----------------------------------------------------------------
	// reduction over the entries younger than len
	// ----------------------------------------------------------------
	always_comb begin
		logic [CFCA_IDX_W-1:0] age;
		age = '0;
		max_conf_o = '0;
		good_sum_o = '0;
		good_cnt_o = '0;
		for (int i = 0; i < DEPTH; i++) begin
			age = wptr_q - CFCA_IDX_W'(i) - 1'b1;
			if (full_q[i] && ({1'b0, age} < len_i)) begin
				if (conf_q[i] > max_conf_o) begin
					max_conf_o = conf_q[i];
				end
				if (good_q[i]) begin
					good_sum_o = good_sum_o + CFCA_SUM_W'(signed'(freq_q[i]));
					good_cnt_o = good_cnt_o + 1'b1;
				end
			end
		end
	end

endmodule

// ==== hw/cfca_top.sv ====
/*
 * cfca_top: adaptive confidence threshold and good-estimate averager of the
 * terrestrial coarse frequency estimator, with its byte register port.
 * assumes: estimates and register accesses come from logic on clk_i; a new
 * estimate arrives only while the block is idle (one per sync sequence).
 */
`timescale 1ns/1ps

// Overview of operation
// R1 - programmable absolute threshold ceiling, reset FF, independent of window history
// R2 - relative ceiling is window maximum confidence minus programmable offset, default 6
// R3 - highest usable threshold is minimum of absolute and relative ceilings
// R4 - raising the threshold adds a programmable step, default 1
// R5 - raise only after a programmable 10-bit count of consecutive good estimates
// R6 - first output after initial delay plus one estimates, delay default 17 hex
// R7 - during the initial phase every estimate counts as good
// R8 - threshold adapts during initial phase, applied from estimate delay plus two
// R9 - estimate is good when confidence is at least the threshold
// R10 - current threshold readable as an 8-bit value
// R11 - each sync sequence gives estimate and confidence; only good ones averaged
// R12 - latest raw estimate and its confidence exponent readable
// R13 - averaged estimate and its confidence exponent readable
// R14 - each good estimate emits a new average to the loop, mirrored in registers
// R15 - output confidence goes to the loop and is readable
// R16 - programmable absolute threshold floor, default 90 hex
// R17 - relative floor is window maximum minus offset 8; lowest is larger floor
// R18 - lowering the threshold subtracts a programmable step, default 1
// R19 - lower only after a programmable 10-bit count of consecutive bad estimates
// R20 - clamp threshold after each step; run counters restart on step or opposite class
module cfca_top
	import cfca_pkg::*;
#(
	parameter int WIN_DEPTH = CFCA_WIN_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic est_valid_i,
	input wire logic [CFCA_EST_W-1:0] est_freq_i,
	input wire logic [CFCA_CONF_W-1:0] est_conf_i,
	output logic loop_valid_o,
	output logic [CFCA_EST_W-1:0] loop_est_o,
	output logic [CFCA_CONF_W-1:0] loop_conf_o,
	output logic busy_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
		sat_sub = (a > b) ? (a - b) : 8'h00;
	endfunction

	function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = s[8] ? 8'hFF : s[7:0];
	endfunction

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [7:0] abs_floor_q;
	logic [7:0] rel_floor_ofs_q;
	logic [7:0] lower_step_q;
	logic [CFCA_RUN_W-1:0] bad_run_count_q;
	logic [7:0] abs_ceil_q;
	logic [7:0] rel_ceil_ofs_q;
	logic [7:0] raise_step_q;
	logic [CFCA_RUN_W-1:0] good_run_count_q;
	logic [CFCA_DLY_W-1:0] init_delay_q;

	wire wr_abs_floor = reg_wr_i && (reg_addr_i == CFCA_OFS_ABS_FLOOR);
	wire wr_rel_floor = reg_wr_i && (reg_addr_i == CFCA_OFS_REL_FLOOR_OFS);
	wire wr_lower_step = reg_wr_i && (reg_addr_i == CFCA_OFS_LOWER_STEP);
	wire wr_bad_lo = reg_wr_i && (reg_addr_i == CFCA_OFS_BAD_RUN_LO);
	wire wr_bad_hi = reg_wr_i && (reg_addr_i == CFCA_OFS_BAD_RUN_HI);
	wire wr_abs_ceil = reg_wr_i && (reg_addr_i == CFCA_OFS_ABS_CEIL);
	wire wr_rel_ceil = reg_wr_i && (reg_addr_i == CFCA_OFS_REL_CEIL_OFS);
	wire wr_raise_step = reg_wr_i && (reg_addr_i == CFCA_OFS_RAISE_STEP);
	wire wr_good_lo = reg_wr_i && (reg_addr_i == CFCA_OFS_GOOD_RUN_LO);
	wire wr_good_hi = reg_wr_i && (reg_addr_i == CFCA_OFS_GOOD_RUN_HI);
	wire wr_init_delay = reg_wr_i && (reg_addr_i == CFCA_OFS_INIT_DELAY);
	wire wr_raw_lo = reg_wr_i && (reg_addr_i == CFCA_OFS_RAW_EST_LO);
	wire wr_raw_hi = reg_wr_i && (reg_addr_i == CFCA_OFS_RAW_EST_HI);
	wire wr_avg_lo = reg_wr_i && (reg_addr_i == CFCA_OFS_AVG_EST_LO);
	wire wr_avg_hi = reg_wr_i && (reg_addr_i == CFCA_OFS_AVG_EST_HI);
	wire wr_loop_lo = reg_wr_i && (reg_addr_i == CFCA_OFS_LOOP_EST_LO);
	wire wr_loop_hi = reg_wr_i && (reg_addr_i == CFCA_OFS_LOOP_EST_HI);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			abs_floor_q <= CFCA_RST_ABS_FLOOR; // [R16]
			rel_floor_ofs_q <= CFCA_RST_REL_FLOOR_OFS; // [R17]
			lower_step_q <= CFCA_RST_LOWER_STEP; // [R18]
			bad_run_count_q <= CFCA_RST_BAD_RUN; // [R19]
			abs_ceil_q <= CFCA_RST_ABS_CEIL; // [R1]
			rel_ceil_ofs_q <= CFCA_RST_REL_CEIL_OFS; // [R2]
			raise_step_q <= CFCA_RST_RAISE_STEP; // [R4]
			good_run_count_q <= CFCA_RST_GOOD_RUN; // [R5]
			init_delay_q <= CFCA_RST_INIT_DELAY; // [R6]
		end else begin
			if (wr_abs_floor) abs_floor_q <= reg_wdata_i;
			if (wr_rel_floor) rel_floor_ofs_q <= reg_wdata_i;
			if (wr_lower_step) lower_step_q <= reg_wdata_i;
			if (wr_bad_lo) bad_run_count_q[7:0] <= reg_wdata_i;
			if (wr_bad_hi) bad_run_count_q[9:8] <= reg_wdata_i[1:0];
			if (wr_abs_ceil) abs_ceil_q <= reg_wdata_i;
			if (wr_rel_ceil) rel_ceil_ofs_q <= reg_wdata_i;
			if (wr_raise_step) raise_step_q <= reg_wdata_i;
			if (wr_good_lo) good_run_count_q[7:0] <= reg_wdata_i;
			if (wr_good_hi) good_run_count_q[9:8] <= reg_wdata_i[1:0];
			if (wr_init_delay) init_delay_q <= reg_wdata_i[4:0];
		end
	end

	// ----------------------------------------------------------------
	// sequencing state
	// ----------------------------------------------------------------
	cfca_state_e state_q;
	cfca_state_e state_d;
	logic [CFCA_EST_W-1:0] in_freq_q;
	logic [CFCA_CONF_W-1:0] in_conf_q;
	logic in_good_q;
	logic in_pass_q;
	logic emit_q;
	logic [CFCA_CNT_W-1:0] seen_q;
	logic [7:0] thr_q;
	logic [CFCA_RUN_W-1:0] good_run_q;
	logic [CFCA_RUN_W-1:0] bad_run_q;
	logic [CFCA_EST_W-1:0] raw_est_q;
	logic [CFCA_CONF_W-1:0] raw_conf_q;
	logic [CFCA_EST_W-1:0] avg_est_q;
	logic [CFCA_CONF_W-1:0] avg_conf_q;
	logic [CFCA_CONF_W-1:0] div_conf_q;

	// ----------------------------------------------------------------
	// window and bounds
	// ----------------------------------------------------------------
	logic [CFCA_CONF_W-1:0] win_max;
	logic signed [CFCA_SUM_W-1:0] win_sum;
	logic [CFCA_CNT_W-1:0] win_cnt;
	wire [CFCA_CNT_W-1:0] win_len = {1'b0, init_delay_q} + 1'b1;

	cfca_window #(
		.DEPTH(WIN_DEPTH)
	) u_window (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.push_i(state_q == CFCA_ST_PUSH),
		.freq_i(in_freq_q),
		.conf_i(in_conf_q),
		.good_i(in_pass_q), // [R11]
		.len_i(win_len),
		.max_conf_o(win_max),
		.good_sum_o(win_sum),
		.good_cnt_o(win_cnt)
	);

	wire [7:0] rel_ceil = sat_sub(win_max, rel_ceil_ofs_q); // [R2]
	wire [7:0] thr_high = (abs_ceil_q < rel_ceil) ? abs_ceil_q : rel_ceil; // [R1] [R3]
	wire [7:0] rel_floor = sat_sub(win_max, rel_floor_ofs_q); // [R17]
	wire [7:0] thr_low = (abs_floor_q > rel_floor) ? abs_floor_q : rel_floor; // [R16] [R17]

	// ----------------------------------------------------------------
	// classification
	// ----------------------------------------------------------------
	wire in_init = ({1'b0, seen_q} <= {2'b00, init_delay_q}); // [R7] [R8]
	wire conf_good = (est_conf_i >= thr_q); // [R9]
	wire take = (state_q == CFCA_ST_IDLE) && est_valid_i;
	wire [CFCA_RUN_W-1:0] good_next = good_run_q + 1'b1;
	wire [CFCA_RUN_W-1:0] bad_next = bad_run_q + 1'b1;
	wire do_raise = in_good_q && (good_next >= good_run_count_q); // [R5]
	wire do_lower = !in_good_q && (bad_next >= bad_run_count_q); // [R19]
	wire [7:0] thr_step = do_raise ? sat_add(thr_q, raise_step_q) : // [R4]
		do_lower ? sat_sub(thr_q, lower_step_q) : thr_q; // [R18]
	wire [7:0] thr_cap = (thr_step > thr_high) ? thr_high : thr_step;
	wire [7:0] thr_clamped = (thr_cap < thr_low) ? thr_low : thr_cap; // [R20]

	// ----------------------------------------------------------------
	// divider for the average of good entries
	// ----------------------------------------------------------------
	logic [CFCA_SUM_W-1:0] quo_q;
	logic [CFCA_CNT_W:0] rem_q;
	logic [CFCA_CNT_W-1:0] dvs_q;
	logic neg_q;
	logic [4:0] div_cnt_q;
	wire [CFCA_SUM_W-1:0] sum_mag = win_sum[CFCA_SUM_W-1] ? CFCA_SUM_W'(-win_sum) : win_sum;
	wire [CFCA_CNT_W+1:0] rem_shift = {rem_q, quo_q[CFCA_SUM_W-1]};
	wire rem_ge = (rem_shift >= {2'b00, dvs_q});
	wire [CFCA_CNT_W+1:0] rem_sub = rem_shift - {2'b00, dvs_q};
	wire div_last = (div_cnt_q == 5'(CFCA_SUM_W - 1));
	wire [CFCA_SUM_W-1:0] quo_next = {quo_q[CFCA_SUM_W-2:0], rem_ge};
	wire [CFCA_EST_W-1:0] avg_result = neg_q ? CFCA_EST_W'(-quo_next) : quo_next[CFCA_EST_W-1:0];

	// ----------------------------------------------------------------
	// state transitions
	// ----------------------------------------------------------------
	always_comb begin
		case (state_q)
			CFCA_ST_IDLE: state_d = est_valid_i ? CFCA_ST_PUSH : CFCA_ST_IDLE;
			CFCA_ST_PUSH: state_d = CFCA_ST_ADAPT;
			CFCA_ST_ADAPT: state_d = CFCA_ST_DIV;
			CFCA_ST_DIV: state_d = div_last ? CFCA_ST_DONE : CFCA_ST_DIV;
			CFCA_ST_DONE: state_d = CFCA_ST_IDLE;
			default: state_d = CFCA_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= CFCA_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// estimate capture and classification
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			in_freq_q <= '0;
			in_conf_q <= '0;
			in_good_q <= 1'b0;
			in_pass_q <= 1'b0;
			emit_q <= 1'b0;
			seen_q <= '0;
		end else if (take) begin
			in_freq_q <= est_freq_i;
			in_conf_q <= est_conf_i;
			in_good_q <= conf_good;
			in_pass_q <= in_init || conf_good; // [R7] [R9]
			emit_q <= in_init ? (seen_q[CFCA_DLY_W-1:0] == init_delay_q) : conf_good; // [R6] [R14]
			if (in_init) seen_q <= seen_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// threshold adaptation
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			thr_q <= CFCA_RST_THR;
			good_run_q <= '0;
			bad_run_q <= '0;
		end else if (state_q == CFCA_ST_ADAPT) begin
			thr_q <= thr_clamped; // [R8] [R20]
			good_run_q <= (!in_good_q || do_raise) ? '0 : good_next; // [R20]
			bad_run_q <= (in_good_q || do_lower) ? '0 : bad_next; // [R20]
		end
	end

	// ----------------------------------------------------------------
	// averaging
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			quo_q <= '0;
			rem_q <= '0;
			dvs_q <= '0;
			neg_q <= 1'b0;
			div_cnt_q <= '0;
			div_conf_q <= '0;
		end else if (state_q == CFCA_ST_ADAPT) begin
			quo_q <= sum_mag;
			rem_q <= '0;
			dvs_q <= (win_cnt == '0) ? CFCA_CNT_W'(1) : win_cnt;
			neg_q <= win_sum[CFCA_SUM_W-1];
			div_cnt_q <= '0;
			div_conf_q <= win_max;
		end else if (state_q == CFCA_ST_DIV) begin
			quo_q <= quo_next;
			rem_q <= rem_ge ? rem_sub[CFCA_CNT_W:0] : rem_shift[CFCA_CNT_W:0];
			div_cnt_q <= div_cnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// observation registers and loop outputs
	// ----------------------------------------------------------------
	wire avg_done = (state_q == CFCA_ST_DIV) && div_last && in_pass_q;
	wire loop_fire = (state_q == CFCA_ST_DIV) && div_last && emit_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			raw_est_q <= '0;
			raw_conf_q <= '0;
			avg_est_q <= '0;
			avg_conf_q <= '0;
			loop_est_o <= '0;
			loop_conf_o <= '0;
			loop_valid_o <= 1'b0;
		end else begin
			loop_valid_o <= loop_fire; // [R14]
			if (take) begin
				raw_est_q <= est_freq_i; // [R11] [R12]
				raw_conf_q <= est_conf_i; // [R12]
			end else begin
				if (wr_raw_lo) raw_est_q[7:0] <= reg_wdata_i;
				if (wr_raw_hi) raw_est_q[15:8] <= reg_wdata_i;
			end
			if (avg_done) begin
				avg_est_q <= avg_result; // [R13]
				avg_conf_q <= div_conf_q; // [R13]
			end else begin
				if (wr_avg_lo) avg_est_q[7:0] <= reg_wdata_i;
				if (wr_avg_hi) avg_est_q[15:8] <= reg_wdata_i;
			end
			if (loop_fire) begin
				loop_est_o <= avg_result; // [R14]
				loop_conf_o <= div_conf_q; // [R15]
			end else begin
				if (wr_loop_lo) loop_est_o[7:0] <= reg_wdata_i;
				if (wr_loop_hi) loop_est_o[15:8] <= reg_wdata_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// register readback
	// ----------------------------------------------------------------
	wire [7:0] rd_mux =
		(reg_addr_i == CFCA_OFS_ABS_FLOOR) ? abs_floor_q :
		(reg_addr_i == CFCA_OFS_REL_FLOOR_OFS) ? rel_floor_ofs_q :
		(reg_addr_i == CFCA_OFS_LOWER_STEP) ? lower_step_q :
		(reg_addr_i == CFCA_OFS_BAD_RUN_LO) ? bad_run_count_q[7:0] :
		(reg_addr_i == CFCA_OFS_BAD_RUN_HI) ? {6'h00, bad_run_count_q[9:8]} :
		(reg_addr_i == CFCA_OFS_ABS_CEIL) ? abs_ceil_q :
		(reg_addr_i == CFCA_OFS_REL_CEIL_OFS) ? rel_ceil_ofs_q :
		(reg_addr_i == CFCA_OFS_RAISE_STEP) ? raise_step_q :
		(reg_addr_i == CFCA_OFS_GOOD_RUN_LO) ? good_run_count_q[7:0] :
		(reg_addr_i == CFCA_OFS_GOOD_RUN_HI) ? {6'h00, good_run_count_q[9:8]} :
		(reg_addr_i == CFCA_OFS_INIT_DELAY) ? {3'h0, init_delay_q} :
		(reg_addr_i == CFCA_OFS_CUR_THR) ? thr_q : // [R10]
		(reg_addr_i == CFCA_OFS_RAW_EST_LO) ? raw_est_q[7:0] :
		(reg_addr_i == CFCA_OFS_RAW_EST_HI) ? raw_est_q[15:8] :
		(reg_addr_i == CFCA_OFS_RAW_CONF) ? raw_conf_q :
		(reg_addr_i == CFCA_OFS_AVG_EST_LO) ? avg_est_q[7:0] :
		(reg_addr_i == CFCA_OFS_AVG_EST_HI) ? avg_est_q[15:8] :
		(reg_addr_i == CFCA_OFS_AVG_CONF) ? avg_conf_q :
		(reg_addr_i == CFCA_OFS_LOOP_EST_LO) ? loop_est_o[7:0] :
		(reg_addr_i == CFCA_OFS_LOOP_EST_HI) ? loop_est_o[15:8] :
		(reg_addr_i == CFCA_OFS_LOOP_CONF) ? loop_conf_o : // [R15]
		8'h00;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 8'h00;
			busy_o <= 1'b0;
		end else begin
			reg_rdata_o <= rd_mux;
			busy_o <= (state_d != CFCA_ST_IDLE);
		end
	end

endmodule

// ==== tb/cfca_top_properties.sv ====
/* cfca_top_properties: port-level checks of cfca_top.
   assumes: bound into cfca_top, one clock, asynchronous active-low reset. */
`timescale 1ns/1ps
module cfca_top_properties
	import cfca_pkg::*;
#(
	parameter int WIN_DEPTH = CFCA_WIN_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic est_valid_i,
	input wire logic [CFCA_EST_W-1:0] est_freq_i,
	input wire logic [CFCA_CONF_W-1:0] est_conf_i,
	input wire logic loop_valid_o,
	input wire logic [CFCA_EST_W-1:0] loop_est_o,
	input wire logic [CFCA_CONF_W-1:0] loop_conf_o,
	input wire logic busy_o
);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	wire take = est_valid_i & ~busy_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_take;
		take;
	endsequence
	sequence s_busy_run;
		busy_o[*8] ##1 busy_o[*8] ##1 busy_o[*8] ##1 !busy_o;
	endsequence
	a_busy_span: assert property (s_take |=> s_busy_run)
		else $error("busy span wrong");
	a_loop_latency: assert property (loop_valid_o |-> $past(take, 24))
		else $error("loop pulse without estimate 24 cycles before");
	a_loop_pulse_one: assert property (loop_valid_o |=> !loop_valid_o)
		else $error("loop pulse too long");
	a_loop_est_hold: assert property (!loop_valid_o |-> $stable(loop_est_o))
		else $error("loop estimate moved between pulses");
	a_loop_conf_hold: assert property (!loop_valid_o |-> $stable(loop_conf_o))
		else $error("loop confidence moved between pulses");
	a_raw_conf_read: assert property (s_take ##1 (reg_addr_i == CFCA_OFS_RAW_CONF) |=>
		reg_rdata_o == $past(est_conf_i, 2))
		else $error("raw confidence readback wrong");
	a_loop_conf_max: assert property (loop_valid_o |-> loop_conf_o >= $past(est_conf_i, 24))
		else $error("loop confidence below window entry");
	a_avg_conf_read: assert property (loop_valid_o ##1 (reg_addr_i == CFCA_OFS_AVG_CONF) |=>
		reg_rdata_o == loop_conf_o)
		else $error("averaged confidence readback wrong");
endmodule
bind cfca_top cfca_top_properties #(.WIN_DEPTH(WIN_DEPTH)) cfca_top_properties_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.est_valid_i(est_valid_i), .est_freq_i(est_freq_i), .est_conf_i(est_conf_i), .loop_valid_o(loop_valid_o),
	.loop_est_o(loop_est_o), .loop_conf_o(loop_conf_o), .busy_o(busy_o));

// ==== tb/cfca_loop_model.sv ====
/* cfca_loop_model: frequency control loop stand-in, counts averaged estimates.
   assumes: loop_valid_i is a one-cycle pulse on clk_i. */
`timescale 1ns/1ps
module cfca_loop_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic loop_valid_i,
	input wire logic [15:0] loop_est_i,
	input wire logic [7:0] loop_conf_i,
	output logic [7:0] pulses_o,
	output logic [15:0] last_est_o,
	output logic [7:0] last_conf_o
);
	// ----------------------------------------------------------------
	// capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pulses_o <= 8'h00;
			last_est_o <= 16'h0000;
			last_conf_o <= 8'h00;
		end else if (loop_valid_i) begin
			pulses_o <= pulses_o + 8'h01;
			last_est_o <= loop_est_i;
			last_conf_o <= loop_conf_i;
		end
	end
endmodule

// ==== tb/cfca_top_test.sv ====
/* cfca_top_test: register and estimate tests of cfca_top.
   assumes: cfca_top, cfca_loop_model and the bound checker are compiled. */
`timescale 1ns/1ps
module cfca_top_test
	import cfca_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and checks
	// ----------------------------------------------------------------
	logic clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, est_valid_i = 1'b0, loop_valid_o, busy_o;
	logic [15:0] reg_addr_i = 16'h0000, est_freq_i = 16'h0000, loop_est_o, last_est;
	logic [7:0] reg_wdata_i = 8'h00, est_conf_i = 8'h00, reg_rdata_o, loop_conf_o, pulses, last_conf;
	logic [15:0] ra [12] = '{16'h0720, 16'h0721, 16'h0722, 16'h0723, 16'h0724, 16'h0726, 16'h0727, 16'h0728,
		16'h0729, 16'h072A, 16'h072B, 16'h072D};
	logic [7:0] rv [12] = '{8'h90, 8'h08, 8'h01, 8'h20, 8'h00, 8'hFF, 8'h06, 8'h01, 8'h01, 8'h00, 8'h17, 8'h90};
	int num_errors = 0, total_checks = 0, cycles = 0;
	cfca_top #(.WIN_DEPTH(CFCA_WIN_DEPTH)) cfca_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .est_valid_i(est_valid_i),
		.est_freq_i(est_freq_i), .est_conf_i(est_conf_i), .loop_valid_o(loop_valid_o), .loop_est_o(loop_est_o),
		.loop_conf_o(loop_conf_o), .busy_o(busy_o));
	cfca_loop_model cfca_loop_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .loop_valid_i(loop_valid_o),
		.loop_est_i(loop_est_o), .loop_conf_i(loop_conf_o), .pulses_o(pulses), .last_est_o(last_est),
		.last_conf_o(last_conf));
	always #5 clk_i = ~clk_i;
	task conclude;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	task rc(input logic [15:0] a, input logic [7:0] exp, input string msg);
		@(negedge clk_i);
		reg_addr_i = a;
		@(negedge clk_i);
		chk(16'(reg_rdata_o), 16'(exp), msg);
	endtask
	task est(input logic [15:0] f, input logic [7:0] c, input logic p, input logic [15:0] avg, input logic [7:0] ac,
		input logic [7:0] thr);
		logic [7:0] n;
		n = pulses;
		@(negedge clk_i);
		est_valid_i = 1'b1;
		est_freq_i = f;
		est_conf_i = c;
		reg_addr_i = CFCA_OFS_RAW_CONF;
		@(negedge clk_i);
		est_valid_i = 1'b0;
		@(negedge clk_i);
		reg_addr_i = CFCA_OFS_AVG_CONF;
		repeat (25) @(negedge clk_i);
		chk(16'(pulses - n), 16'(p), "loop output count");
		if (p) begin
			chk(last_est, avg, "averaged estimate");
			chk(16'(last_conf), 16'(ac), "averaged confidence");
		end
		rc(CFCA_OFS_CUR_THR, thr, "threshold");
	endtask
	initial begin
		repeat (16) @(negedge clk_i);
		rst_b_i = 1'b1;
		for (int i = 0; i < 12; i++) rc(ra[i], rv[i], "reset value");
		wr(CFCA_OFS_INIT_DELAY, 8'hFF);
		rc(CFCA_OFS_INIT_DELAY, 8'h1F, "delay width");
		wr(CFCA_OFS_GOOD_RUN_HI, 8'hFF);
		rc(CFCA_OFS_GOOD_RUN_HI, 8'h03, "run count width");
		wr(CFCA_OFS_CUR_THR, 8'h00);
		rc(CFCA_OFS_CUR_THR, 8'h90, "read-only threshold");
		rc(16'h072C, 8'h00, "unmapped read");
		wr(CFCA_OFS_GOOD_RUN_HI, 8'h00);
		$display("test registers done");
		wr(CFCA_OFS_INIT_DELAY, 8'h03);
		wr(CFCA_OFS_REL_FLOOR_OFS, 8'h20);
		wr(CFCA_OFS_RAISE_STEP, 8'h03);
		est(16'h000A, 8'h10, 1'b0, 16'h0000, 8'h00, 8'h90);
		est(16'h0014, 8'h10, 1'b0, 16'h0000, 8'h00, 8'h90);
		est(16'h001E, 8'h10, 1'b0, 16'h0000, 8'h00, 8'h90);
		est(16'h0029, 8'h10, 1'b1, 16'h0019, 8'h10, 8'h90);
		est(16'h0007, 8'h10, 1'b0, 16'h0000, 8'h00, 8'h90);
		est(16'h0032, 8'hA0, 1'b1, 16'h0028, 8'hA0, 8'h93);
		wr(CFCA_OFS_ABS_CEIL, 8'h94);
		est(16'h003C, 8'h93, 1'b1, 16'h0032, 8'hA0, 8'h94);
		wr(CFCA_OFS_ABS_CEIL, 8'hFF);
		wr(CFCA_OFS_REL_CEIL_OFS, 8'h0F);
		est(16'hFFC4, 8'h94, 1'b1, 16'h0010, 8'hA0, 8'h91);
		wr(CFCA_OFS_ABS_FLOOR, 8'h80);
		wr(CFCA_OFS_LOWER_STEP, 8'h02);
		wr(CFCA_OFS_BAD_RUN_LO, 8'h01);
		est(16'h0000, 8'h10, 1'b0, 16'h0000, 8'h00, 8'h8F);
		wr(CFCA_OFS_GOOD_RUN_LO, 8'h02);
		est(16'h000A, 8'hA0, 1'b1, 16'h0003, 8'hA0, 8'h8F);
		est(16'h0014, 8'hA0, 1'b1, 16'hFFF6, 8'hA0, 8'h91);
		rc(CFCA_OFS_RAW_EST_LO, 8'h14, "raw estimate low");
		rc(CFCA_OFS_RAW_EST_HI, 8'h00, "raw estimate high");
		rc(CFCA_OFS_AVG_EST_LO, 8'hF6, "averaged estimate low");
		rc(CFCA_OFS_AVG_EST_HI, 8'hFF, "averaged estimate high");
		rc(CFCA_OFS_LOOP_EST_HI, 8'hFF, "loop estimate high");
		rc(CFCA_OFS_LOOP_CONF, 8'hA0, "loop confidence");
		wr(CFCA_OFS_RAW_EST_LO, 8'h5A);
		rc(CFCA_OFS_RAW_EST_LO, 8'h5A, "raw estimate write");
		$display("test estimates done");
		conclude();
	end
endmodule
